// ### hdl/lin_resp_pkg.sv
// Package: constants, types and register map of the response controller
`default_nettype none
package lin_resp_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [2:0] OFS_CTRL   = 3'h0;
    localparam logic [2:0] OFS_STATUS = 3'h1;
    localparam logic [2:0] OFS_IRQ_EN = 3'h2;
    localparam logic [2:0] OFS_ERROR  = 3'h3;
    localparam logic [2:0] OFS_LENGTH = 3'h4;
    localparam logic [2:0] OFS_IDENT  = 3'h5;

    // Control register fields
    localparam int CTRL_LIN13 = 3;
    localparam int CTRL_UART  = 4;
    // Status register fields
    localparam int ST_RX_DONE = 0;
    localparam int ST_TX_DONE = 1;
    localparam int ST_HDR_OK  = 2;
    localparam int ST_ERR     = 3;
    localparam int ST_BUSY    = 4;
    // Error register fields
    localparam int ERR_BIT     = 0;
    localparam int ERR_CSUM    = 1;
    localparam int ERR_PARITY  = 2;
    localparam int ERR_SYNC    = 3;
    localparam int ERR_FRAME   = 4;
    localparam int ERR_TIMEOUT = 5;
    localparam int ERR_OVERRUN = 6;
    localparam int ERR_ABORT   = 7;

    // Reset values, length limit and checksum target
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [3:0] RST_LEN   = 4'h0;
    localparam logic [3:0] MAX_LEN   = 4'h8;
    localparam logic [7:0] CSUM_GOOD = 8'hFF;

    // Frame timing, in bit times
    localparam int HDR_BITS  = 34;
    localparam int BYTE_BITS = 10;
    localparam int TOL_NUM   = 14;
    localparam int TOL_DEN   = 10;

    typedef enum logic [2:0] {
        CMD_ABORT     = 3'b000,
        CMD_TX_HEADER = 3'b001,
        CMD_RX_RESP   = 3'b010,
        CMD_TX_RESP   = 3'b011
    } cmd_t;

    typedef enum logic [1:0] {
        S_IDLE   = 2'b00,
        S_HEADER = 2'b01,
        S_RX     = 2'b10,
        S_TX     = 2'b11
    } state_t;

    // Events from the bit-level serializer
    typedef struct packed {
        logic       header_done;
        logic [7:0] pid;
        logic       rx_valid;
        logic [7:0] rx_byte;
        logic       stop_bad;
        logic       tx_sent;
        logic       bit_check;
        logic       bit_sent;
        logic       bit_seen;
        logic       sync_bad;
        logic       break_sync;
        logic       bit_tick;
        logic       uart_overwrite;
    } link_evt_t;
endpackage : lin_resp_pkg
`default_nettype wire

// ### hdl/lin_response_ctrl.sv
// Response length, completion flags, errors and checksum of the LIN/UART
// ****************************************************************
// Overview of operation
// - Length zero moves only the checksum
// - LIN 2.1 lengths above eight clamp to eight
// - LIN 1.3 lengths decoded from identifier
// - Receive: transmit field cleared, counts received bytes
// - Receive error stops, count holds good bytes
// - Transmit: receive field cleared, counts sent bytes
// - Transmit error stops, count holds sent bytes
// - UART mode and reset zero both lengths
// - Header end sets header flag, not UART
// - Done flags per response, or per character
// - Summary is OR; writing one clears all
// - Monitored bit mismatch sets bit error, aborts
// - Received sum plus checksum must be FF
// - Identifier parity mismatch sets parity error
// - Bad synch edges set sync error
// - Dominant stop bit sets framing error
// - Frame longer than maximum sets timeout
// - Non-abort command while busy sets overrun
// - Abort while busy flagged; errors other than overrun clear command
// - Checksum is inverted sum with carry
// - Break inside data aborts with error
// - Four flags gated onto two interrupts
// - Busy is set and cleared by hardware
// ****************************************************************
//
// Design decisions made here: the register addresses and the strobed register port.
`default_nettype none
module lin_response_ctrl (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic [2:0]             addr,
    input  wire logic [7:0]             wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output logic      [7:0]             rdata,
    input  wire lin_resp_pkg::link_evt_t evt,
    input  wire logic [7:0]             tx_data_in,
    output logic                        tx_start,
    output logic      [7:0]             tx_byte,
    output logic      [3:0]             data_index,
    output logic                        rx_store,
    output logic      [7:0]             rx_data,
    output logic                        busy,
    output logic                        irq_transfer,
    output logic                        irq_error
);
    import lin_resp_pkg::*;

    // ****************************************************************
    // Functions
    // ****************************************************************
    function automatic logic [7:0] csum_add(input logic [7:0] s,
                                            input logic [7:0] b);
        logic [8:0] t;
        t = {1'b0, s} + {1'b0, b};
        return t[7:0] + {7'h00, t[8]};
    endfunction : csum_add

    function automatic logic [3:0] clamp_len(input logic [3:0] l);
        return (l > MAX_LEN) ? MAX_LEN : l;
    endfunction : clamp_len

    function automatic logic [3:0] decode_len(input logic [7:0] p);
        case (p[5:4])
            2'b11:   return 4'h8;
            2'b10:   return 4'h4;
            default: return 4'h2;
        endcase
    endfunction : decode_len

    function automatic logic parity_ok(input logic [7:0] p);
        logic p0;
        logic p1;
        p0 = p[0] ^ p[1] ^ p[2] ^ p[4];
        p1 = ~(p[1] ^ p[3] ^ p[4] ^ p[5]);
        return (p[6] == p0) && (p[7] == p1);
    endfunction : parity_ok

    function automatic logic [7:0] frame_max(input logic [3:0] l);
        int bits;
        bits = (TOL_NUM * (HDR_BITS + BYTE_BITS * (int'(l) + 1))) / TOL_DEN;
        return bits[7:0];
    endfunction : frame_max

    // ****************************************************************
    // State
    // ****************************************************************
    state_t     state;
    cmd_t       cmd;
    logic       lin13;
    logic       uart_mode;
    logic [3:0] rx_len;
    logic [3:0] tx_len;
    logic [7:0] ident;
    logic [7:0] sum;
    logic       tx_wait;
    logic       tx_last;
    logic       rx_done;
    logic       tx_done;
    logic       hdr_ok;
    logic [7:0] err_reg;
    logic [3:0] irq_en;
    logic       timer_on;
    logic [7:0] timer;
    logic [7:0] timer_lim;

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire        wr_ctrl   = wr && (addr == OFS_CTRL);
    wire        wr_status = wr && (addr == OFS_STATUS);
    wire        wr_len    = wr && (addr == OFS_LENGTH);
    wire        wr_ident  = wr && (addr == OFS_IDENT);
    wire cmd_t  wcmd      = cmd_t'(wdata[2:0]);
    wire        w_uart    = wdata[CTRL_UART];
    wire        w_lin13   = wdata[CTRL_LIN13];

    assign busy = (state != S_IDLE);

    wire cmd_abort   = wr_ctrl && busy && (wcmd == CMD_ABORT);
    wire cmd_overrun = wr_ctrl && busy && (wcmd != CMD_ABORT);
    wire go          = wr_ctrl && !busy && !w_uart;
    wire go_rx       = go && (wcmd == CMD_RX_RESP);
    wire go_tx       = go && (wcmd == CMD_TX_RESP);
    wire go_hdr      = go && (wcmd == CMD_TX_HEADER);

    wire hdr_evt     = evt.header_done && !uart_mode &&
                       ((state == S_IDLE) || (state == S_HEADER));
    wire rx_evt      = evt.rx_valid && (state == S_RX);
    wire rx_good     = rx_evt && !evt.stop_bad;
    wire rx_is_csum  = (tx_len == rx_len);
    wire csum_match  = (csum_add(sum, evt.rx_byte) == CSUM_GOOD);
    wire rx_finish   = rx_good && rx_is_csum && csum_match;
    wire tx_evt      = evt.tx_sent && (state == S_TX) && tx_wait;
    wire tx_finish   = tx_evt && tx_last;
    wire timed_out   = timer_on && (timer >= timer_lim);

    // Error sources, one per error bit
    wire [7:0] err_set;
    assign err_set[ERR_BIT]     = (state == S_TX) &&
        ((evt.bit_check && (evt.bit_sent != evt.bit_seen))
         || evt.break_sync);
    assign err_set[ERR_CSUM]    = rx_good && rx_is_csum && !csum_match;
    assign err_set[ERR_PARITY]  = hdr_evt && !parity_ok(evt.pid);
    assign err_set[ERR_SYNC]    = evt.sync_bad && !uart_mode;
    assign err_set[ERR_FRAME]   = (evt.rx_valid && evt.stop_bad &&
                                   (uart_mode || state == S_RX))
                                  || ((state == S_RX) && evt.break_sync);
    assign err_set[ERR_TIMEOUT] = timed_out;
    assign err_set[ERR_OVERRUN] = cmd_overrun
                                  || (uart_mode && evt.uart_overwrite);
    assign err_set[ERR_ABORT]   = cmd_abort;

    wire any_err   = |err_set;
    // Overrun leaves the transfer running; every other error stops it
    wire stop_err  = |(err_set & ~(8'h01 << ERR_OVERRUN));
    wire clr_err   = wr_status && wdata[ST_ERR];
    wire err_sum   = |err_reg;

    // ****************************************************************
    // Control and sequencing
    // ****************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state     <= S_IDLE;
            cmd       <= CMD_ABORT;
            lin13     <= 1'b0;
            uart_mode <= 1'b0;
        end else if (stop_err) begin
            state <= S_IDLE;
            cmd   <= CMD_ABORT;
        end else if (wr_ctrl && !busy) begin
            cmd       <= wcmd;
            lin13     <= w_lin13;
            uart_mode <= w_uart;
            if (go_rx) begin
                state <= S_RX;
            end else if (go_tx) begin
                state <= S_TX;
            end else if (go_hdr) begin
                state <= S_HEADER;
            end
        end else if (hdr_evt || rx_finish || tx_finish) begin
            state <= S_IDLE;
        end
    end

    // ****************************************************************
    // Length fields and byte counting
    // ****************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rx_len <= RST_LEN;
            tx_len <= RST_LEN;
        end else if (uart_mode) begin
            rx_len <= RST_LEN;
            tx_len <= RST_LEN;
        end else if (go_rx) begin
            tx_len <= RST_LEN;
            rx_len <= w_lin13 ? rx_len : clamp_len(rx_len);
        end else if (go_tx) begin
            rx_len <= RST_LEN;
            tx_len <= w_lin13 ? tx_len : clamp_len(tx_len);
        end else if (hdr_evt && lin13) begin
            rx_len <= decode_len(evt.pid);
            tx_len <= decode_len(evt.pid);
        end else if (rx_good && !rx_is_csum) begin
            tx_len <= tx_len + 4'h1;
        end else if (tx_evt && !tx_last) begin
            rx_len <= rx_len + 4'h1;
        end else if (wr_len && !busy) begin
            rx_len <= wdata[3:0];
            tx_len <= wdata[7:4];
        end
    end

    // ****************************************************************
    // Identifier and running checksum
    // ****************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ident <= RST_BYTE;
        end else if (hdr_evt) begin
            ident <= evt.pid;
        end else if (wr_ident && !busy && !uart_mode) begin
            ident <= wdata;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sum <= RST_BYTE;
        end else if (go_rx || go_tx) begin
            sum <= w_lin13 ? RST_BYTE : ident;
        end else if (rx_good && !rx_is_csum) begin
            sum <= csum_add(sum, evt.rx_byte);
        end else if (tx_evt && !tx_last) begin
            sum <= csum_add(sum, tx_byte);
        end
    end

    // ****************************************************************
    // Transmit byte feed
    // ****************************************************************
    assign data_index = (state == S_TX) ? rx_len : tx_len;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_start <= 1'b0;
            tx_byte  <= RST_BYTE;
            tx_wait  <= 1'b0;
            tx_last  <= 1'b0;
        end else if (state == S_TX && !tx_wait && !stop_err) begin
            tx_start <= 1'b1;
            tx_last  <= (rx_len == tx_len);
            tx_byte  <= (rx_len == tx_len) ? ~sum : tx_data_in;
            tx_wait  <= 1'b1;
        end else begin
            tx_start <= 1'b0;
            if (tx_evt || state != S_TX) begin
                tx_wait <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Receive byte output
    // ****************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rx_store <= 1'b0;
            rx_data  <= RST_BYTE;
        end else begin
            rx_store <= (rx_good && !rx_is_csum) ||
                        (uart_mode && evt.rx_valid && !evt.stop_bad);
            if (rx_good || (uart_mode && evt.rx_valid)) begin
                rx_data <= evt.rx_byte;
            end
        end
    end

    // ****************************************************************
    // Frame timer
    // ****************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            timer_on  <= 1'b0;
            timer     <= RST_BYTE;
            timer_lim <= RST_BYTE;
        end else if (stop_err || rx_finish || tx_finish || uart_mode) begin
            timer_on <= 1'b0;
        end else if (hdr_evt) begin
            timer_on  <= 1'b1;
            timer     <= RST_BYTE;
            timer_lim <= frame_max(lin13 ? decode_len(evt.pid) : MAX_LEN);
        end else if (timer_on) begin
            if (go_rx) begin
                timer_lim <= frame_max(w_lin13 ? rx_len : clamp_len(rx_len));
            end else if (go_tx) begin
                timer_lim <= frame_max(w_lin13 ? tx_len : clamp_len(tx_len));
            end
            if (evt.bit_tick) begin
                timer <= timer + 8'h01;
            end
        end
    end

    // ****************************************************************
    // Flags, error register, interrupt enables
    // ****************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rx_done <= 1'b0;
            tx_done <= 1'b0;
            hdr_ok  <= 1'b0;
            err_reg <= RST_BYTE;
        end else begin
            rx_done <= rx_finish || (uart_mode && evt.rx_valid) ||
                       (rx_done && !(wr_status && wdata[ST_RX_DONE]));
            tx_done <= tx_finish || (uart_mode && evt.tx_sent) ||
                       (tx_done && !(wr_status && wdata[ST_TX_DONE]));
            hdr_ok  <= hdr_evt ||
                       (hdr_ok && !(wr_status && wdata[ST_HDR_OK]));
            err_reg <= err_set | (clr_err ? RST_BYTE : err_reg);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_en <= RST_LEN;
        end else if (wr && addr == OFS_IRQ_EN) begin
            irq_en <= wdata[3:0];
        end
    end

    assign irq_transfer = (rx_done && irq_en[ST_RX_DONE]) ||
                          (tx_done && irq_en[ST_TX_DONE]) ||
                          (hdr_ok && irq_en[ST_HDR_OK]);
    assign irq_error    = err_sum && irq_en[ST_ERR];

    // ****************************************************************
    // Read port
    // ****************************************************************
    wire [7:0] status_rd = {3'b000, busy, err_sum, hdr_ok, tx_done, rx_done};
    wire [7:0] ctrl_rd   = {3'b000, uart_mode, lin13, cmd};
    logic [7:0] rd_mux;

    always_comb begin
        case (addr)
            OFS_CTRL:   rd_mux = ctrl_rd;
            OFS_STATUS: rd_mux = status_rd;
            OFS_IRQ_EN: rd_mux = {4'h0, irq_en};
            OFS_ERROR:  rd_mux = err_reg;
            OFS_LENGTH: rd_mux = {tx_len, rx_len};
            OFS_IDENT:  rd_mux = ident;
            default:    rd_mux = RST_BYTE;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata <= RST_BYTE;
        end else begin
            rdata <= rd ? rd_mux : RST_BYTE;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_clamp;
        (go_rx || go_tx) && !w_lin13 |=>
            (rx_len <= MAX_LEN) && (tx_len <= MAX_LEN);
    endproperty
    a_clamp: assert property (p_clamp) else $error("length not clamped");

    property p_rx_start;
        go_rx |=> (tx_len == 4'h0) && (state == S_RX);
    endproperty
    a_rx_start: assert property (p_rx_start) else $error("rx start bad");

    property p_uart_len;
        uart_mode |=> (rx_len == 4'h0) && (tx_len == 4'h0);
    endproperty
    a_uart_len: assert property (p_uart_len) else $error("uart length");

    property p_hdr;
        hdr_evt |=> hdr_ok ##0 (state == S_IDLE);
    endproperty
    a_hdr: assert property (p_hdr) else $error("header flag missing");

    property p_err_clear;
        clr_err && !any_err |=> !err_sum && !irq_error;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("err clear");

    property p_bit_err;
        (state == S_TX) && evt.bit_check && (evt.bit_sent != evt.bit_seen)
            |=> err_reg[ERR_BIT] && (state == S_IDLE) && (cmd == CMD_ABORT);
    endproperty
    a_bit_err: assert property (p_bit_err) else $error("bit error");

    property p_overrun;
        cmd_overrun |=> err_reg[ERR_OVERRUN] && $stable(cmd);
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun");

    property p_abort;
        cmd_abort |=> err_reg[ERR_ABORT] && !busy;
    endproperty
    a_abort: assert property (p_abort) else $error("abort");

    property p_rx_count;
        rx_good && !rx_is_csum && !any_err |=> tx_len == $past(tx_len) + 4'h1;
    endproperty
    a_rx_count: assert property (p_rx_count) else $error("rx count");

    property p_irq;
        rx_done && irq_en[ST_RX_DONE] |-> irq_transfer;
    endproperty
    a_irq: assert property (p_irq) else $error("irq gating");
endmodule : lin_response_ctrl
`default_nettype wire

// ### verif/lin_node_model.sv
// Far-side LIN node: headers, received bytes, answers to sent bytes
`default_nettype none
module lin_node_model (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   tx_start,
    input  wire logic [7:0]             tx_byte,
    input  wire logic                   flip,
    input  wire logic                   tick_on,
    output lin_resp_pkg::link_evt_t     evt,
    output logic      [7:0]             last_tx
);
    timeunit 1ns;
    timeprecision 1ps;
    import lin_resp_pkg::*;
    logic       hd = 1'b0;
    logic       rv = 1'b0;
    logic       sb = 1'b0;
    logic       ts;
    logic       bc;
    logic [7:0] pid = 8'h00;
    logic [7:0] rb = 8'h00;
    logic [1:0] cnt;
    // Monitored bit reads back inverted when flip is set
    assign evt = '{hd, pid, rv, rb, sb, ts, bc, 1'b1, ~flip, 1'b0, 1'b0,
                   tick_on, 1'b0};
    // ****************************************************************
    // Sent byte: one monitored bit, then done two cycles later
    // ****************************************************************
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt     <= 2'h0;
            ts      <= 1'b0;
            bc      <= 1'b0;
            last_tx <= 8'h00;
        end else begin
            ts  <= (cnt == 2'h1);
            bc  <= (cnt == 2'h3);
            cnt <= tx_start ? 2'h3 : cnt - {1'b0, cnt != 2'h0};
            if (tx_start) begin
                last_tx <= tx_byte;
            end
        end
    end
    task automatic header(input logic [7:0] p);
        @(posedge clk);
        hd  <= 1'b1;
        pid <= p;
        @(posedge clk);
        hd  <= 1'b0;
        pid <= ~p;
    endtask : header
    task automatic rx(input logic [7:0] b, input logic bad);
        @(posedge clk);
        rv <= 1'b1;
        rb <= b;
        sb <= bad;
        @(posedge clk);
        rv <= 1'b0;
        rb <= ~b;
        sb <= 1'b0;
    endtask : rx
endmodule : lin_node_model
`default_nettype wire

// ### verif/lin_response_length_flags_checksum_tb.sv
// Testbench of the response controller
`default_nettype none
module lin_response_length_flags_checksum_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lin_resp_pkg::*;
    logic clk, reset, wr, rd, tx_start, rx_store, busy, flip, tick_on;
    logic irq_transfer, irq_error;
    logic [2:0] addr;
    logic [3:0] data_index;
    logic [7:0] wdata, rdata, tx_byte, rx_data, last_tx, v;
    link_evt_t  evt;
    int bad_count = 0;
    int checked = 0;
    int stores = 0;
    // Buffer holds bytes 1, 2, 3, 4 at indices 0..3
    wire [7:0] tx_data_in = {4'h0, data_index} + 8'h01;
    lin_response_ctrl u_lin_response_ctrl (.clk(clk), .reset(reset),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .evt(evt), .tx_data_in(tx_data_in), .tx_start(tx_start),
        .tx_byte(tx_byte), .data_index(data_index), .rx_store(rx_store),
        .rx_data(rx_data), .busy(busy), .irq_transfer(irq_transfer),
        .irq_error(irq_error));
    lin_node_model u_lin_node_model (.clk(clk), .reset(reset),
        .tx_start(tx_start), .tx_byte(tx_byte), .flip(flip),
        .tick_on(tick_on), .evt(evt), .last_tx(last_tx));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Data bytes handed to the buffer
    always @(posedge clk) begin
        if (rx_store === 1'b1) stores++;
    end
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e) begin
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
            bad_count++;
        end
    endtask : check
    task automatic w(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : w
    task automatic rc(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        check(rdata, e);
    endtask : rc
    task automatic idle_wait;
        repeat (2) @(posedge clk);
        for (int n = 0; n < 200 && busy !== 1'b0; n++) @(negedge clk);
    endtask : idle_wait
    task automatic t_rx;
        w(OFS_CTRL, 8'h08);
        u_lin_node_model.header(8'h20);
        repeat (2) @(posedge clk);
        rc(OFS_LENGTH, 8'h44);
        rc(OFS_STATUS, 8'h04);
        w(OFS_IRQ_EN, 8'h01);
        w(OFS_CTRL, 8'h0A);
        rc(OFS_LENGTH, 8'h04);
        for (int i = 1; i < 5; i++) u_lin_node_model.rx(i[7:0], 1'b0);
        u_lin_node_model.rx(8'hF5, 1'b0);
        idle_wait();
        check(stores[7:0], 8'h04);
        check(rx_data, 8'hF5);
        rc(OFS_LENGTH, 8'h44);
        rc(OFS_STATUS, 8'h05);
        check({7'h0, irq_transfer}, 8'h01);
        w(OFS_STATUS, 8'h07);
        $display("rx response done");
    endtask : t_rx
    task automatic t_tx;
        w(OFS_CTRL, 8'h0B);
        rc(OFS_LENGTH, 8'h40);
        idle_wait();
        check(last_tx, 8'hF5);
        rc(OFS_LENGTH, 8'h44);
        rc(OFS_STATUS, 8'h02);
        w(OFS_STATUS, 8'h07);
        $display("tx response done");
    endtask : t_tx
    task automatic t_cmd;
        w(OFS_CTRL, 8'h0A);
        w(OFS_CTRL, 8'h0B);
        w(OFS_CTRL, 8'h08);
        rc(OFS_ERROR, 8'hC0);
        check({7'h0, busy}, 8'h00);
        w(OFS_IRQ_EN, 8'h08);
        @(negedge clk);
        check({7'h0, irq_error}, 8'h01);
        rc(OFS_STATUS, 8'h08);
        w(OFS_STATUS, 8'h08);
        rc(OFS_ERROR, 8'h00);
        $display("commands done");
    endtask : t_cmd
    task automatic t_rx_err;
        w(OFS_CTRL, 8'h0A);
        for (int i = 1; i < 5; i++) u_lin_node_model.rx(i[7:0], 1'b0);
        u_lin_node_model.rx(8'h00, 1'b0);
        idle_wait();
        rc(OFS_ERROR, 8'h02);
        w(OFS_STATUS, 8'h08);
        w(OFS_CTRL, 8'h0A);
        u_lin_node_model.rx(8'h01, 1'b0);
        u_lin_node_model.rx(8'h02, 1'b0);
        u_lin_node_model.rx(8'h03, 1'b1);
        idle_wait();
        rc(OFS_ERROR, 8'h10);
        rc(OFS_LENGTH, 8'h24);
        w(OFS_STATUS, 8'h08);
        $display("rx errors done");
    endtask : t_rx_err
    task automatic t_bit;
        flip <= 1'b1;
        w(OFS_CTRL, 8'h0B);
        idle_wait();
        rc(OFS_ERROR, 8'h01);
        rc(OFS_LENGTH, 8'h20);
        w(OFS_STATUS, 8'h08);
        flip <= 1'b0;
        $display("bit error done");
    endtask : t_bit
    task automatic t_len21;
        w(OFS_CTRL, 8'h00);
        w(OFS_LENGTH, 8'h0F);
        w(OFS_CTRL, 8'h02);
        rc(OFS_LENGTH, 8'h08);
        w(OFS_CTRL, 8'h00);
        w(OFS_LENGTH, 8'h00);
        w(OFS_STATUS, 8'h0F);
        w(OFS_CTRL, 8'h03);
        idle_wait();
        rc(OFS_STATUS, 8'h02);
        check(last_tx, 8'hDF);
        w(OFS_STATUS, 8'h07);
        $display("lin 2.1 lengths done");
    endtask : t_len21
    task automatic t_timeout;
        w(OFS_CTRL, 8'h08);
        u_lin_node_model.header(8'h80);
        tick_on <= 1'b1;
        repeat (250) @(posedge clk);
        tick_on <= 1'b0;
        rc(OFS_ERROR, 8'h20);
        w(OFS_STATUS, 8'h0F);
        $display("timeout done");
    endtask : t_timeout
    task automatic t_uart;
        w(OFS_CTRL, 8'h10);
        rc(OFS_LENGTH, 8'h00);
        w(OFS_LENGTH, 8'h33);
        rc(OFS_LENGTH, 8'h00);
        u_lin_node_model.header(8'h20);
        rc(OFS_STATUS, 8'h00);
        u_lin_node_model.rx(8'h5A, 1'b0);
        rc(OFS_STATUS, 8'h01);
        check(rx_data, 8'h5A);
        $display("uart done");
    endtask : t_uart
    task automatic print_verdict;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    initial begin
        #100000;
        bad_count++;
        print_verdict();
    end
    initial begin
        {addr, wdata, wr, rd, flip, tick_on} = '0;
        reset = 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rc(OFS_LENGTH, 8'h00);
        rc(OFS_ERROR, 8'h00);
        t_rx();
        t_tx();
        t_cmd();
        t_rx_err();
        t_bit();
        t_len21();
        t_timeout();
        t_uart();
        print_verdict();
    end
endmodule : lin_response_length_flags_checksum_tb
`default_nettype wire
